//--- design/jlsm_mapper.sv
`timescale 1ns/1ps
`include "jlsm_defines.svh"

module jlsm_mapper (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [6:0]   lane_mapping_select,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [255:0] sample_data,
  input  wire logic [7:0]   i_overrange_flag,
  input  wire logic [7:0]   q_overrange_flag,
  input  wire logic         chan_a_i_overrange,
  input  wire logic         chan_a_q_overrange,
  input  wire logic         chan_b_i_overrange,
  input  wire logic         chan_b_q_overrange,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [511:0]      lane_data,
  output logic [15:0]       lane_drv_en,
  input  wire logic         sync_hdr_sel,
  output jlsm_pkg::jlsm_sync_t sync_hdr_mode_q,
  input  wire logic         power_down_pin,
  input  wire logic         cfg_power_down,
  input  wire logic         chan_a_power_down,
  input  wire logic         chan_b_power_down,
  output logic              powered_down_q
);

  // ****************************************
  // Mode decode and field helpers
  // ****************************************

  function automatic jlsm_pkg::jlsm_kind_t kind_of(input logic [6:0] m);
    unique case (m)
      `JLSM_M20, `JLSM_M43: kind_of = jlsm_pkg::JLSM_K_DB12_12;
      `JLSM_M21, `JLSM_M36,
      `JLSM_M24, `JLSM_M48, `JLSM_M62, `JLSM_M65, `JLSM_M70: kind_of = jlsm_pkg::JLSM_K_SD_4;
      `JLSM_M22, `JLSM_M46,
      `JLSM_M26, `JLSM_M54, `JLSM_M63: kind_of = jlsm_pkg::JLSM_K_SD_8;
      `JLSM_M23, `JLSM_M38, `JLSM_M61, `JLSM_M64, `JLSM_M69, `JLSM_M71: kind_of = jlsm_pkg::JLSM_K_SD_2;
      `JLSM_M25, `JLSM_M52: kind_of = jlsm_pkg::JLSM_K_SD4_16;
      `JLSM_M27: kind_of = jlsm_pkg::JLSM_K_SD8_16;
      `JLSM_M32: kind_of = jlsm_pkg::JLSM_K_SB12_6;
      `JLSM_M33: kind_of = jlsm_pkg::JLSM_K_DB12_6;
      `JLSM_M34: kind_of = jlsm_pkg::JLSM_K_S8_4;
      `JLSM_M35: kind_of = jlsm_pkg::JLSM_K_D8_4;
      `JLSM_M37: kind_of = jlsm_pkg::JLSM_K_DD_4;
      `JLSM_M39, `JLSM_M56: kind_of = jlsm_pkg::JLSM_K_DD_2;
      default: kind_of = jlsm_pkg::JLSM_K_NONE;
    endcase
  endfunction : kind_of

  // Low octet of one input slot, for the 8-bit mappings
  function automatic logic [7:0] slot(input logic [255:0] d, input int k);
    slot = d[k*`JLSM_SLOT_W +: 8];
  endfunction : slot

  // Four 12-bit samples back to back, MSB first, starting at slot k
  function automatic logic [47:0] pack12(input logic [255:0] d, input int k, input int step);
    pack12 = {d[k*16 +: 12], d[(k+step)*16 +: 12], d[(k+2*step)*16 +: 12], d[(k+3*step)*16 +: 12]};
  endfunction : pack12

  // Decimated word: 15-bit sample then its over-range flag
  function automatic logic [15:0] dec(input logic [255:0] d, input int k, input logic f);
    dec = {d[k*16 +: 15], f};
  endfunction : dec

  // ****************************************
  // Lane mapping
  // ****************************************

  jlsm_pkg::jlsm_kind_t kind;
  logic [511:0]         map_w;
  logic [15:0]          map_m;
  logic                 pd_all;
  logic                 dual;

  assign kind   = kind_of(lane_mapping_select);
  assign pd_all = power_down_pin | cfg_power_down;    // R16 R17
  assign dual   = kind inside {jlsm_pkg::JLSM_K_DB12_12, jlsm_pkg::JLSM_K_DB12_6, jlsm_pkg::JLSM_K_D8_4,
                               jlsm_pkg::JLSM_K_DD_4, jlsm_pkg::JLSM_K_DD_2};

  // Frame placement; every lane starts zero so unused lanes carry nothing
  always_comb begin
    logic [47:0] p;
    int          n;
    p     = '0;
    n     = 0;
    map_w = '0;    // R20
    map_m = '0;    // R20
    unique case (kind)
      jlsm_pkg::JLSM_K_DB12_12, jlsm_pkg::JLSM_K_DB12_6, jlsm_pkg::JLSM_K_SB12_6: begin
        for (int g = 0; g < 2; g++) begin
          for (int h = 0; h < 2; h++) begin
            if (kind == jlsm_pkg::JLSM_K_SB12_6) begin
              p = pack12(sample_data, g + h * 8, 2);    // R9
            end else begin
              p = pack12(sample_data, g * `JLSM_B_SLOT0 + h * 4, 1);    // R1 R10
            end
            if (h == 0 || kind == jlsm_pkg::JLSM_K_DB12_12) begin
              for (int j = 0; j < 3; j++) begin
                map_w[(g * `JLSM_B_LANE0 + h * 3 + j) * 32 + 16 +: 16] = p[47 - 16 * j -: 16];
                map_m[g * `JLSM_B_LANE0 + h * 3 + j] = 1'b1;
              end
            end
          end
        end
      end
      jlsm_pkg::JLSM_K_SD_2, jlsm_pkg::JLSM_K_SD_4, jlsm_pkg::JLSM_K_SD_8,
      jlsm_pkg::JLSM_K_SD4_16, jlsm_pkg::JLSM_K_SD8_16: begin
        unique case (kind)
          jlsm_pkg::JLSM_K_SD_2: n = 1;    // R4
          jlsm_pkg::JLSM_K_SD_4: n = 2;    // R2 R5
          jlsm_pkg::JLSM_K_SD_8: n = 4;    // R3 R7
          default:               n = 8;    // R6 R8
        endcase
        for (int k = 0; k < 8; k++) begin
          if (k < n) begin
            // Decimate-by-4 over 16 lanes gives one flag per sample pair
            if (kind == jlsm_pkg::JLSM_K_SD4_16) begin
              map_w[k * 32 + 16 +: 16] = dec(sample_data, k, i_overrange_flag[k / 2]);    // R6
              map_w[(k + 8) * 32 + 16 +: 16] = dec(sample_data, k + 8, q_overrange_flag[k / 2]);    // R6
            end else begin
              map_w[k * 32 + 16 +: 16] = dec(sample_data, k, i_overrange_flag[k]);    // R2 R3 R4 R5 R7 R8
              map_w[(k + 8) * 32 + 16 +: 16] = dec(sample_data, k + 8, q_overrange_flag[k]);    // R2 R3 R4 R5 R7 R8
            end
            map_m[k]     = 1'b1;
            map_m[k + 8] = 1'b1;
          end
        end
      end
      jlsm_pkg::JLSM_K_S8_4: begin
        map_w[0 * 32 + 24 +: 8] = slot(sample_data, 0);    // R11
        map_w[1 * 32 + 24 +: 8] = slot(sample_data, 2);    // R11
        map_w[8 * 32 + 24 +: 8] = slot(sample_data, 1);    // R11
        map_w[9 * 32 + 24 +: 8] = slot(sample_data, 3);    // R11
        map_m = 16'h0303;
      end
      jlsm_pkg::JLSM_K_D8_4: begin
        map_w[0 * 32 + 24 +: 8] = slot(sample_data, 0);    // R12
        map_w[1 * 32 + 24 +: 8] = slot(sample_data, 1);    // R12
        map_w[8 * 32 + 24 +: 8] = slot(sample_data, 8);    // R12
        map_w[9 * 32 + 24 +: 8] = slot(sample_data, 9);    // R12
        map_m = 16'h0303;
      end
      jlsm_pkg::JLSM_K_DD_4: begin
        map_w[0 * 32 + 16 +: 16] = dec(sample_data, 0, chan_a_i_overrange);    // R13
        map_w[1 * 32 + 16 +: 16] = dec(sample_data, 1, chan_a_q_overrange);    // R13
        map_w[8 * 32 + 16 +: 16] = dec(sample_data, 8, chan_b_i_overrange);    // R13
        map_w[9 * 32 + 16 +: 16] = dec(sample_data, 9, chan_b_q_overrange);    // R13
        map_m = 16'h0303;
      end
      jlsm_pkg::JLSM_K_DD_2: begin
        map_w[0 * 32 +: 32] = {dec(sample_data, 0, chan_a_i_overrange), dec(sample_data, 1, chan_a_q_overrange)};    // R14
        map_w[8 * 32 +: 32] = {dec(sample_data, 8, chan_b_i_overrange), dec(sample_data, 9, chan_b_q_overrange)};    // R14
        map_m = 16'h0101;
      end
      default: begin
      end
    endcase
    // Single channel off in dual operation silences its lane group
    if (dual && chan_a_power_down) begin
      map_w[255:0] = '0;    // R17
      map_m[7:0]   = '0;    // R17
    end
    if (dual && chan_b_power_down) begin
      map_w[511:256] = '0;    // R17
      map_m[15:8]    = '0;    // R17
    end
  end

  // ****************************************
  // Two-entry output buffer
  // ****************************************

  logic [511:0] buf_w_q [`JLSM_BUF_DEPTH];
  logic [1:0]   cnt_q;
  logic         wr_q;
  logic         rd_q;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_q != 2'h2) && !pd_all;    // R16
  assign out_valid = (cnt_q != 2'h0) && !pd_all;    // R16
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign lane_data = buf_w_q[rd_q];

  // Storage; a stall downstream fills both entries, then in_ready drops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      buf_w_q[0] <= '0;
      buf_w_q[1] <= '0;
    end else if (push) begin
      buf_w_q[wr_q] <= map_w;
    end
  end

  // Pointers; power-down flushes, so no stale frame leaves after wake-up
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'h0;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else if (pd_all) begin
      cnt_q <= 2'h0;    // R16
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      wr_q  <= wr_q ^ push;
      rd_q  <= rd_q ^ pop;
    end
  end

  // ****************************************
  // Drivers, sync header, power state
  // ****************************************

  // Drivers follow the live mode mask; a mode change retunes them on the next clock edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lane_drv_en    <= 16'h0000;
      powered_down_q <= 1'b1;
    end else begin
      lane_drv_en    <= pd_all ? 16'h0000 : map_m;    // R16 R17 R20
      powered_down_q <= pd_all;    // R16 R17
    end
  end

  // Only two header streams exist, so no CRC-3 code can be chosen
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_hdr_mode_q <= jlsm_pkg::JLSM_SH_CRC12;
    end else begin
      sync_hdr_mode_q <= sync_hdr_sel ? jlsm_pkg::JLSM_SH_FEC : jlsm_pkg::JLSM_SH_CRC12;    // R15
    end
  end

  // ****************************************
  // Assertions
  // ****************************************

  // Lane-wide copy of the driver mask, so idle lanes can be checked for stray data
  logic [511:0] lane_mask_w;
  always_comb begin
    for (int l = 0; l < 16; l++) begin
      lane_mask_w[l * 32 +: 32] = {32{map_m[l]}};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  pd_drivers_off_a: assert property (power_down_pin |=> lane_drv_en == 16'h0000 && !out_valid)    // R16
    else $error("drivers on during power-down");
  mode_pd_off_a: assert property (cfg_power_down |-> !in_ready && !out_valid ##1 powered_down_q)    // R17
    else $error("mode power-down ignored");
  unused_lanes_a: assert property ((map_w & ~lane_mask_w) == '0 &&
                                   (kind != jlsm_pkg::JLSM_K_NONE || map_m == 16'h0000))    // R20
    else $error("data on an unused lane");
  byp12_dual_a: assert property (kind == jlsm_pkg::JLSM_K_DB12_12 && !chan_b_power_down |->
                                 map_w[13 * 32 + 16 +: 16] == {sample_data[14*16 +: 4], sample_data[15*16 +: 12]})    // R1
    else $error("dual bypass lane B5 wrong");
  byp12_single_a: assert property (kind == jlsm_pkg::JLSM_K_SB12_6 |->
                                   map_w[1 * 32 + 16 +: 16] == {sample_data[2*16 +: 8], sample_data[4*16+4 +: 8]})    // R9
    else $error("single bypass lane A1 wrong");
  oct8_order_a: assert property (kind == jlsm_pkg::JLSM_K_S8_4 |->
                                 map_w[1 * 32 + 24 +: 8] == sample_data[2*16 +: 8] && map_m == 16'h0303)    // R11
    else $error("8-bit lane A1 wrong");
  pair_flag_a: assert property (kind == jlsm_pkg::JLSM_K_SD4_16 |->
                                map_w[7 * 32 + 16] == i_overrange_flag[3] && map_w[13 * 32 + 16] == q_overrange_flag[2])    // R6
    else $error("shared flag index wrong");
  own_flag_a: assert property (kind == jlsm_pkg::JLSM_K_SD8_16 |-> map_w[15 * 32 + 16] == q_overrange_flag[7])    // R8
    else $error("own flag index wrong");
  dual_dec2_a: assert property (kind == jlsm_pkg::JLSM_K_DD_2 && !chan_a_power_down |->
                                map_w[15:0] == {sample_data[16 +: 15], chan_a_q_overrange})    // R14
    else $error("dual 2-lane Q octets wrong");
  sync_sel_a: assert property (sync_hdr_sel |=> sync_hdr_mode_q == jlsm_pkg::JLSM_SH_FEC)    // R15
    else $error("sync header select lost");
  buf_hold_a: assert property (out_valid && !out_ready && !pd_all |=> $stable(lane_data) && cnt_q != 2'h0)
    else $error("stalled word changed");
  byp12_six_a: assert property (kind == jlsm_pkg::JLSM_K_DB12_6 && !chan_b_power_down |->    // R10
                                map_w[10 * 32 + 16 +: 16] == {sample_data[10*16 +: 4], sample_data[11*16 +: 12]} &&
                                map_m[15:11] == 5'h00)
    else $error("dual 6-lane bypass lane B2 wrong");
  dec8_two_a: assert property (kind == jlsm_pkg::JLSM_K_SD_2 |->    // R4
                               map_w[8 * 32 + 16 +: 16] == {sample_data[8*16 +: 15], q_overrange_flag[0]} &&
                               map_m == 16'h0101)
    else $error("two-lane Q word wrong");
  oct8_dual_a: assert property (kind == jlsm_pkg::JLSM_K_D8_4 && !chan_b_power_down |->    // R12
                                map_w[8 * 32 + 24 +: 8] == sample_data[8*16 +: 8])
    else $error("8-bit dual lane B0 wrong");
  dd4_lanes_a: assert property (kind == jlsm_pkg::JLSM_K_DD_4 && !chan_b_power_down |->    // R13
                                map_w[9 * 32 + 16 +: 16] == {sample_data[9*16 +: 15], chan_b_q_overrange})
    else $error("dual 4-lane BQ wrong");
  chan_off_a: assert property (dual && chan_b_power_down |=> lane_drv_en[15:8] == 8'h00)    // R17
    else $error("powered-down channel drivers on");

  full_stall_c: cover property (cnt_q == 2'h2 && !in_ready);
  pd_wake_c: cover property (powered_down_q ##1 !powered_down_q);
  dual_dec2_c: cover property (kind == jlsm_pkg::JLSM_K_DD_2 && push);
  chan_off_c: cover property (dual && chan_b_power_down && push);
  sync_fec_c: cover property (sync_hdr_sel ##1 sync_hdr_mode_q == jlsm_pkg::JLSM_SH_FEC);

endmodule : jlsm_mapper

//--- design/jlsm_defines.svh
`ifndef JLSM_DEFINES_SVH
`define JLSM_DEFINES_SVH
// Overview of operation
// R1: Dual 12-bit bypass, 12 lanes: eight A samples over A0-A5, eight B over B0-B5.
// R2: Single decimate-4, 4 lanes: I with flags on A0-A1, Q on B0-B1.
// R3: Single decimate-4, 8 lanes: I0-I3 on A0-A3, Q0-Q3 on B0-B3.
// R4: Single decimate-8, 2 lanes: one I on A0, one Q on B0.
// R5: Single decimate-8, 4 lanes: I0-I1 on A0-A1, Q0-Q1 on B0-B1.
// R6: Single decimate-4, 16 lanes: eight I and Q, pairs share flag index.
// R7: Single decimate-8, 8 lanes: I0-I3 on A0-A3, Q0-Q3 on B0-B3.
// R8: Single decimate-8, 16 lanes: eight I and Q, each its own flag.
// R9: Single 12-bit bypass, 6 lanes: even samples on A0-A2, odd on B0-B2.
// R10: Dual 12-bit bypass, 6 lanes: A0-A3 over A0-A2, B0-B3 over B0-B2.
// R11: 8-bit single, 4 lanes: S0 A0, S2 A1, S1 B0, S3 B1.
// R12: 8-bit dual, 4 lanes: A0-A1 on A0-A1, B0-B1 on B0-B1.
// R13: Dual decimate-4, 4 lanes: AI A0, AQ A1, BI B0, BQ B1.
// R14: Dual decimated 2 lanes: I in octets 0-1, Q in octets 2-3.
// R15: Sync header selectable as CRC-12 or FEC; no CRC-3 choice.
// R16: Power-down pin high powers down and disables serial drivers.
// R17: Mode field full power-down; per-channel power-down in dual operation.
// R18: Controller sets converter-off calibration field before power-down; the bench powers down with no such write.
// R19: Receiver re-establishes link and discards stale data after power-up.
// R20: One mapping at a time; unused lanes carry no sample data.

// Lane geometry
`define JLSM_NUM_LANES   16
`define JLSM_LANE_W      32
`define JLSM_SLOT_W      16
`define JLSM_NUM_SLOTS   16
`define JLSM_B_LANE0     8
`define JLSM_B_SLOT0     8
`define JLSM_BUF_DEPTH   2

// Output mode codes
`define JLSM_M20 7'h14
`define JLSM_M43 7'h2b
`define JLSM_M21 7'h15
`define JLSM_M36 7'h24
`define JLSM_M22 7'h16
`define JLSM_M46 7'h2e
`define JLSM_M23 7'h17
`define JLSM_M38 7'h26
`define JLSM_M61 7'h3d
`define JLSM_M64 7'h40
`define JLSM_M69 7'h45
`define JLSM_M71 7'h47
`define JLSM_M24 7'h18
`define JLSM_M48 7'h30
`define JLSM_M62 7'h3e
`define JLSM_M65 7'h41
`define JLSM_M70 7'h46
`define JLSM_M25 7'h19
`define JLSM_M52 7'h34
`define JLSM_M26 7'h1a
`define JLSM_M54 7'h36
`define JLSM_M63 7'h3f
`define JLSM_M27 7'h1b
`define JLSM_M32 7'h20
`define JLSM_M33 7'h21
`define JLSM_M34 7'h22
`define JLSM_M35 7'h23
`define JLSM_M37 7'h25
`define JLSM_M39 7'h27
`define JLSM_M56 7'h38
`endif

//--- design/jlsm_pkg.sv
package jlsm_pkg;
  // Lane layout family selected by the output mode
  typedef enum logic [3:0] {
    JLSM_K_NONE    = 4'h0,
    JLSM_K_DB12_12 = 4'h1,
    JLSM_K_SB12_6  = 4'h2,
    JLSM_K_DB12_6  = 4'h3,
    JLSM_K_SD_2    = 4'h4,
    JLSM_K_SD_4    = 4'h5,
    JLSM_K_SD_8    = 4'h6,
    JLSM_K_SD4_16  = 4'h7,
    JLSM_K_SD8_16  = 4'h8,
    JLSM_K_S8_4    = 4'h9,
    JLSM_K_D8_4    = 4'ha,
    JLSM_K_DD_4    = 4'hb,
    JLSM_K_DD_2    = 4'hc
  } jlsm_kind_t;

  typedef enum logic {
    JLSM_SH_CRC12 = 1'b0,
    JLSM_SH_FEC   = 1'b1
  } jlsm_sync_t;
endpackage : jlsm_pkg

//--- tb/jlsm_rx_model.sv
`timescale 1ns/1ps
// ****
// Receiver model
// ****
module jlsm_rx_model (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         stall,
  input  wire logic         powered_down,
  input  wire logic         out_valid,
  input  wire logic [511:0] lane_data,
  output logic              out_ready,
  output logic [511:0]      last_q
);
  // Stalls only when the bench commands it
  assign out_ready = !stall;

  // Frame capture; a power-down drops what was held, since it is stale
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_q <= '0;
    end else if (powered_down) begin
      last_q <= '0;
    end else if (out_valid && out_ready) begin
      last_q <= lane_data;
    end
  end
endmodule : jlsm_rx_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] FI = 8'h5a;
  localparam logic [7:0] FQ = 8'ha5;
  localparam logic [3:0] FD = 4'h9;
  logic         clock, resetn, in_valid, in_ready, out_valid, out_ready;
  logic         stall, sync_sel, pd_pin, pd_cfg, pd_a, pd_b, pdq;
  logic [6:0]   mode;
  logic [255:0] sd;
  logic [511:0] lane_data, rx_last;
  logic [15:0]  lane_drv_en;
  jlsm_pkg::jlsm_sync_t sync_q;
  int           n_fail, tests_run, cyc;

  jlsm_mapper u_dut (.clock(clock), .resetn(resetn), .lane_mapping_select(mode), .in_valid(in_valid),
    .in_ready(in_ready), .sample_data(sd), .i_overrange_flag(FI), .q_overrange_flag(FQ),
    .chan_a_i_overrange(FD[0]), .chan_a_q_overrange(FD[1]), .chan_b_i_overrange(FD[2]),
    .chan_b_q_overrange(FD[3]), .out_valid(out_valid), .out_ready(out_ready), .lane_data(lane_data),
    .lane_drv_en(lane_drv_en), .sync_hdr_sel(sync_sel), .sync_hdr_mode_q(sync_q), .power_down_pin(pd_pin),
    .cfg_power_down(pd_cfg), .chan_a_power_down(pd_a), .chan_b_power_down(pd_b), .powered_down_q(pdq));

  jlsm_rx_model u_rx (.clock(clock), .resetn(resetn), .stall(stall), .powered_down(pdq),
    .out_valid(out_valid), .lane_data(lane_data), .out_ready(out_ready), .last_q(rx_last));

  // ****
  // Expected frames
  // ****
  function automatic logic [15:0] sl(input int k, input logic [3:0] s);
    return 16'(k * 4951 + s * 3855 + 9320);
  endfunction : sl

  // Modes that share a layout fold onto the first mode of that layout
  function automatic logic [6:0] base(input logic [6:0] m);
    case (m)
      7'h2b: return 7'h14;
      7'h24: return 7'h15;
      7'h2e: return 7'h16;
      7'h26, 7'h3d, 7'h40, 7'h45, 7'h47: return 7'h17;
      7'h30, 7'h3e, 7'h41, 7'h46: return 7'h18;
      7'h34: return 7'h19;
      7'h36, 7'h3f: return 7'h1a;
      7'h38: return 7'h27;
      default: return m;
    endcase
  endfunction : base

  function automatic logic [511:0] ex(input logic [6:0] m, input logic [3:0] s);
    logic [511:0] e;
    logic [95:0]  a, b;
    int           n, d, l, k;
    e = '0;
    a = '0;
    b = '0;
    case (m)
      7'h14, 7'h2b, 7'h20, 7'h21: begin
        n = (m == 7'h20 || m == 7'h21) ? 4 : 8;
        for (int i = 0; i < n; i++) begin
          a = {a[83:0], 12'(sl(m == 7'h20 ? 2 * i : i, s))};
          b = {b[83:0], 12'(sl(m == 7'h20 ? 2 * i + 1 : 8 + i, s))};
        end
        if (n == 4) begin
          a = a << 48;
          b = b << 48;
        end
        for (int j = 0; j < n * 3 / 4; j++) begin
          e[32 * j + 16 +: 16] = a[95 - 16 * j -: 16];
          e[32 * j + 272 +: 16] = b[95 - 16 * j -: 16];
        end
      end
      7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b: begin
        n = (m == 7'h17) ? 1 : (m == 7'h15 || m == 7'h18) ? 2 : (m == 7'h19 || m == 7'h1b) ? 8 : 4;
        d = (m == 7'h19) ? 2 : 1;
        for (int j = 0; j < n; j++) begin
          e[32 * j + 16 +: 16] = {15'(sl(j, s)), FI[j / d]};
          e[32 * j + 272 +: 16] = {15'(sl(8 + j, s)), FQ[j / d]};
        end
      end
      7'h22, 7'h23, 7'h25: begin
        for (int j = 0; j < 4; j++) begin
          l = (j < 2) ? j : 6 + j;
          k = (m != 7'h22) ? l : (j < 2) ? 2 * j : 2 * j - 3;
          if (m == 7'h25) e[32 * l + 16 +: 16] = {15'(sl(k, s)), FD[j]};
          else e[32 * l + 24 +: 8] = 8'(sl(k, s));
        end
      end
      7'h27: begin
        e[31:0] = {15'(sl(0, s)), FD[0], 15'(sl(1, s)), FD[1]};
        e[287:256] = {15'(sl(8, s)), FD[2], 15'(sl(9, s)), FD[3]};
      end
      default: e = '0;
    endcase
    return e;
  endfunction : ex

  function automatic logic [15:0] mk(input logic [6:0] m);
    case (m)
      7'h14, 7'h2b: return 16'h3f3f;
      7'h20, 7'h21: return 16'h0707;
      7'h17, 7'h27: return 16'h0101;
      7'h19, 7'h1b: return 16'hffff;
      7'h16, 7'h1a: return 16'h0f0f;
      default: return 16'h0303;
    endcase
  endfunction : mk

  // ****
  // Shared bench tasks
  // ****
  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic push(input logic [3:0] s);
    int n;
    n = 0;
    @(negedge clock);
    in_valid = 1'b1;
    for (int k = 0; k < 16; k++) sd[16 * k +: 16] = sl(k, s);
    while (in_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
  endtask : push

  task automatic idle_wait();
    int n;
    n = 0;
    @(negedge clock);
    in_valid = 1'b0;
    while (out_valid !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
  endtask : idle_wait

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // ****
  // Scenarios
  // ****
  task automatic t_modes();
    logic [6:0] ml[30] = '{7'h14, 7'h2b, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h20,
                           7'h21, 7'h22, 7'h23, 7'h25, 7'h27, 7'h24, 7'h2e, 7'h26, 7'h3d, 7'h40,
                           7'h45, 7'h47, 7'h30, 7'h3e, 7'h41, 7'h46, 7'h34, 7'h36, 7'h3f, 7'h38};
    foreach (ml[i]) begin
      @(negedge clock);
      mode = ml[i];
      push(4'(i));
      idle_wait();
      chk(lane_data, ex(base(ml[i]), 4'(i)));
      chk(512'(lane_drv_en), 512'(mk(base(ml[i]))));
    end
    @(negedge clock);
    mode = 7'h01;
    repeat (2) @(negedge clock);
    chk(512'(lane_drv_en), 512'h0);
    $display("mode mapping test done");
  endtask : t_modes

  task automatic t_stall();
    @(negedge clock);
    stall = 1'b1;
    mode = 7'h16;
    push(4'h1);
    push(4'h2);
    idle_wait();
    chk(512'(in_ready), 512'h0);
    chk(lane_data, ex(7'h16, 4'h1));
    stall = 1'b0;
    @(negedge clock);
    chk(lane_data, ex(7'h16, 4'h2));
    @(negedge clock);
    chk(512'(out_valid), 512'h0);
    chk(rx_last, ex(7'h16, 4'h2));
    $display("stall test done");
  endtask : t_stall

  task automatic t_sync();
    for (int v = 0; v < 2; v++) begin
      @(negedge clock);
      sync_sel = v[0];
      @(negedge clock);
      chk(512'(sync_q), 512'(v));
    end
    $display("sync header test done");
  endtask : t_sync

  task automatic t_pd();
    for (int s = 0; s < 2; s++) begin
      @(negedge clock);
      stall = 1'b1;
      push(4'h3);
      idle_wait();
      // No foreground calibration runs here, so no converter-off write precedes power-down
      {pd_pin, pd_cfg} = s ? 2'b01 : 2'b10;
      repeat (2) @(negedge clock);
      chk({pdq, in_ready, out_valid, lane_drv_en}, {1'b1, 1'b0, 1'b0, 16'h0});
      {pd_pin, pd_cfg} = 2'b00;
      stall = 1'b0;
      repeat (2) @(negedge clock);
      chk({out_valid, lane_drv_en}, {1'b0, 16'h0f0f});
    end
    @(negedge clock);
    mode = 7'h23;
    pd_a = 1'b1;
    push(4'h5);
    idle_wait();
    chk(512'(lane_drv_en), 512'h0300);
    chk(lane_data, ex(7'h23, 4'h5) & {{256{1'b1}}, 256'h0});
    pd_a = 1'b0;
    pd_b = 1'b1;
    push(4'h6);
    idle_wait();
    chk(512'(lane_drv_en), 512'h0003);
    chk(lane_data, ex(7'h23, 4'h6) & {256'h0, {256{1'b1}}});
    pd_b = 1'b0;
    $display("power-down test done");
  endtask : t_pd

  // ****
  // Clock, reset, sequence and watchdog
  // ****
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    {resetn, in_valid, stall, sync_sel, pd_pin, pd_cfg, pd_a, pd_b} = '0;
    mode = 7'h14;
    sd = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    resetn = 1'b1;
    t_modes();
    t_stall();
    t_sync();
    t_pd();
    final_report();
  end

  // Cuts a hang short well past the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
endmodule : tb_top
